// ===== rtl/fdc_pkg.sv
package fdc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Card organisation
  localparam int ROW_BITS = 10;
  localparam int COL_BITS = 10;
  localparam int WORD_ADDR_BITS = ROW_BITS + COL_BITS;
  localparam int DATA_BITS = 32;
  localparam int LANES = 4;
  localparam int PD_BITS = 8;
  // Timing figures in ns, ms and us as named
  localparam int PAGE_CYCLE_TIME_NS = 45;
  localparam int ADDRESS_ACCESS_TIME_NS = 46;
  localparam int RANDOM_CYCLE_TIME_NS = 130;
  localparam int ROW_PRECHARGE_NS = 50;
  localparam int ROW_TO_COL_NS = 20;
  localparam int COL_PULSE_NS = 21;
  localparam int COL_PRECHARGE_NS = 10;
  localparam int REFRESH_PERIOD_MS = 128;
  localparam int REFRESH_ROWS = 1024;
  localparam int BATTERY_PERIOD_US = 125;
  localparam int BATTERY_PULSE_US = 1;
  // Least times round up, longest round down
  localparam int PAGE_CYCLE_CYC = (PAGE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RANDOM_CYCLE_CYC = (RANDOM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TO_COL_CYC = (ROW_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_PULSE_CYC = (COL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_PRE_CYC = (COL_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_PERIOD_MS * 1000000 / REFRESH_ROWS) / CLK_PERIOD_NS;
  localparam int BATTERY_PERIOD_CYC = BATTERY_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int BATTERY_PULSE_CYC = BATTERY_PULSE_US * 1000 / CLK_PERIOD_NS;
  // Presence-detect field positions
  localparam int PD_ADDR_LSB = 0;
  localparam int PD_ADDR_MSB = 3;
  localparam int PD_BANKS_BIT = 4;
  localparam int PD_SPEED_BIT = 5;
  localparam int PD_REFRESH_BIT = 7;

  typedef enum logic [1:0] {
    FDC_OP_READ,
    FDC_OP_WRITE,
    FDC_OP_REFRESH_ROW,
    FDC_OP_REFRESH_CBR
  } fdc_op_t;

  typedef struct packed {
    fdc_op_t op;
    logic [WORD_ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] wdata;
    logic [LANES-1:0] byte_en;
    logic page_hold;
  } fdc_req_t;

  typedef struct packed {
    logic [1:0] row_strobe_n;
    logic [LANES-1:0] col_strobe_n;
    logic write_enable_n;
    logic [ROW_BITS-1:0] addr;
  } fdc_pins_t;
endpackage

// ===== rtl/fdc_pulse_div.sv
// One-cycle enable every PERIOD cycles
module fdc_pulse_div #(
  parameter int PERIOD = 125000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  output logic tick
);
  logic [31:0] count;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (clear) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count == 32'(PERIOD - 1)) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ===== rtl/fdc_host.sv
// Summary of operation
// - Word address splits into a 10-bit row then a 10-bit column.
// - Successive page column cycles start at least 45 ns apart.
// - Page read keeps row low, WE high, new column per column fall.
// - Page write keeps row low, WE low, data with each column fall.
// - Refresh by row-only, column-before-row, or battery-backup method.
// - Issue 1024 refreshes spread over each 128 ms.
// - Battery refresh: column low, WE high, row pulse <=1 us per 125 us.
module fdc_host
  import fdc_pkg::*;
#(
  parameter int REFRESH_CYC = fdc_pkg::REFRESH_INTERVAL_CYC,
  parameter int BATTERY_CYC = fdc_pkg::BATTERY_PERIOD_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Request port
  input wire logic REQ_VALID,
  input wire fdc_pkg::fdc_req_t REQ,
  input wire logic MODE_X16,
  input wire logic BATTERY_MODE,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [fdc_pkg::DATA_BITS-1:0] RD_DATA,
  output logic [fdc_pkg::PD_BITS-1:0] CARD_ID,
  // Card pins
  output fdc_pkg::fdc_pins_t PINS,
  output logic [fdc_pkg::DATA_BITS-1:0] DQ_OUT,
  output logic DQ_OE,
  input wire logic [fdc_pkg::DATA_BITS-1:0] DQ_IN,
  input wire logic [fdc_pkg::PD_BITS-1:0] PD_IN
);
  import fdc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_COL_PRE, ST_PAGE_WAIT, ST_RAS_OFF,
    ST_CBR_SETUP, ST_CBR_ROW, ST_BATT
  } fdc_state_t;

  fdc_state_t state;
  logic [15:0] tmr;
  logic [15:0] row_tmr;
  logic [ROW_BITS-1:0] open_row;
  logic open_bank;
  logic page_rd;
  fdc_req_t cur;
  logic refresh_pending;
  logic refresh_tick;
  logic batt_tick;
  logic [DATA_BITS-1:0] dq_s1, dq_s2;
  logic [PD_BITS-1:0] pd_s1, pd_s2;

  // Bank and lane selection for the current request
  function automatic logic bank_of(input logic [WORD_ADDR_BITS-1:0] a, input logic x16);
    bank_of = x16 & a[WORD_ADDR_BITS-1];
  endfunction

  function automatic logic [LANES-1:0] lanes_n(input logic [LANES-1:0] be,
                                                input logic x16, input logic bank);
    logic [LANES-1:0] m;
    m = be;
    if (x16) begin
      m = bank ? {be[3:2], 2'b00} : {2'b00, be[1:0]};
    end
    lanes_n = ~m;
  endfunction

  fdc_pulse_div #(.PERIOD(REFRESH_CYC)) u_ref (
    .clk(CLK), .resetn(RESETN), .clear(1'b0), .tick(refresh_tick));
  fdc_pulse_div #(.PERIOD(BATTERY_CYC)) u_batt (
    .clk(CLK), .resetn(RESETN), .clear(!BATTERY_MODE), .tick(batt_tick));

  // Two flops on pin inputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      pd_s1 <= '0;
      pd_s2 <= '0;
    end else begin
      dq_s1 <= DQ_IN;
      dq_s2 <= dq_s1;
      pd_s1 <= PD_IN;
      pd_s2 <= pd_s1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CARD_ID <= '0;
    end else begin
      CARD_ID <= pd_s2;
    end
  end

  // refresh owed, tick wins over service
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      refresh_pending <= 1'b0;
    end else if (refresh_tick) begin
      refresh_pending <= 1'b1;
    end else if (state == ST_CBR_ROW && tmr == 16'h0) begin
      refresh_pending <= 1'b0;
    end
  end

  // cycles left before the next row strobe fall is allowed
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      row_tmr <= 16'h0;
    end else if (state == ST_ROW || state == ST_CBR_ROW || state == ST_BATT) begin
      // A battery pulse is a row cycle as well
      if (tmr == 16'h0) begin
        row_tmr <= 16'(RANDOM_CYCLE_CYC);
      end else if (row_tmr != 16'h0) begin
        row_tmr <= row_tmr - 16'h1;
      end
    end else if (row_tmr != 16'h0) begin
      row_tmr <= row_tmr - 16'h1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
      tmr <= 16'h0;
      cur <= '0;
      open_row <= '0;
      open_bank <= 1'b0;
      page_rd <= 1'b0;
      PINS <= '{row_strobe_n: 2'b11, col_strobe_n: '1, write_enable_n: 1'b1, addr: '0};
      DQ_OUT <= '0;
      DQ_OE <= 1'b0;
      REQ_READY <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= '0;
    end else begin
      RD_VALID <= 1'b0;
      REQ_READY <= 1'b0;
      if (tmr != 16'h0) begin
        tmr <= tmr - 16'h1;
      end
      case (state)
        ST_IDLE: begin
          if (BATTERY_MODE) begin
            // column low, WE high while in backup
            PINS.col_strobe_n <= '0;
            PINS.write_enable_n <= 1'b1;
            if (batt_tick) begin
              PINS.row_strobe_n <= 2'b00;
              tmr <= 16'(BATTERY_PULSE_CYC - 1);
              state <= ST_BATT;
            end
          end else if (row_tmr == 16'h0 && tmr == 16'h0 &&
                       (refresh_pending || (REQ_VALID && REQ.op == FDC_OP_REFRESH_CBR))) begin
            // column-before-row refresh; one pass serves timer and request
            REQ_READY <= REQ_VALID && REQ.op == FDC_OP_REFRESH_CBR;
            PINS.col_strobe_n <= '0;
            PINS.write_enable_n <= 1'b1;
            tmr <= 16'(ROW_TO_COL_CYC);
            state <= ST_CBR_SETUP;
          end else if (row_tmr == 16'h0 && tmr == 16'h0 && REQ_VALID) begin
            // Waiting on tmr keeps the row precharge after the last row rise
            REQ_READY <= 1'b1;
            cur <= REQ;
            PINS.col_strobe_n <= '1;
            PINS.addr <= REQ.addr[WORD_ADDR_BITS-1 -: ROW_BITS];
            tmr <= 16'h0;
            state <= ST_ROW;
          end else begin
            PINS.col_strobe_n <= '1;
          end
        end
        ST_ROW: begin
          if (cur.op == FDC_OP_REFRESH_ROW || !MODE_X16) begin
            PINS.row_strobe_n <= MODE_X16 ? 2'b10 : 2'b00;
            if (cur.op == FDC_OP_REFRESH_ROW && MODE_X16) begin
              // Row-only refresh strobes the bank picked by address bit 0
              PINS.row_strobe_n <= cur.addr[0] ? 2'b01 : 2'b10;
            end
          end else begin
            PINS.row_strobe_n <= bank_of(cur.addr, 1'b1) ? 2'b01 : 2'b10;
          end
          open_row <= cur.addr[WORD_ADDR_BITS-1 -: ROW_BITS];
          open_bank <= bank_of(cur.addr, MODE_X16);
          // WE low for write, high otherwise
          PINS.write_enable_n <= (cur.op != FDC_OP_WRITE);
          page_rd <= (cur.op == FDC_OP_READ);
          tmr <= 16'(ROW_TO_COL_CYC);
          state <= (cur.op == FDC_OP_REFRESH_ROW) ? ST_COL_PRE : ST_COL;
          if (cur.op == FDC_OP_REFRESH_ROW) begin
            tmr <= 16'(PAGE_CYCLE_CYC);
          end
        end
        ST_COL: begin
          if (tmr == 16'h0) begin
            PINS.addr <= cur.addr[COL_BITS-1:0];
            // one strobe per enabled byte lane; x16 mode keeps only the two lanes of the open bank
            PINS.col_strobe_n <= lanes_n(cur.byte_en, MODE_X16, open_bank);
            DQ_OUT <= cur.wdata;
            DQ_OE <= (cur.op == FDC_OP_WRITE);
            // page cycle spacing; access wait plus sync delay
            tmr <= 16'(PAGE_CYCLE_CYC > ACCESS_CYC + 2 ? PAGE_CYCLE_CYC : ACCESS_CYC + 2);
            state <= ST_COL_PRE;
          end
        end
        ST_COL_PRE: begin
          if (tmr == 16'h0) begin
            if (cur.op == FDC_OP_READ) begin
              // sample no earlier than access time
              RD_DATA <= dq_s2;
              RD_VALID <= 1'b1;
            end
            PINS.col_strobe_n <= '1;
            DQ_OE <= 1'b0;
            tmr <= 16'(COL_PRE_CYC);
            state <= cur.page_hold ? ST_PAGE_WAIT : ST_RAS_OFF;
          end
        end
        ST_PAGE_WAIT: begin
          // same row, same WE, new column only
          if (REQ_VALID && tmr == 16'h0 && !refresh_pending &&
              REQ.addr[WORD_ADDR_BITS-1 -: ROW_BITS] == open_row &&
              bank_of(REQ.addr, MODE_X16) == open_bank &&
              (REQ.op == FDC_OP_READ) == page_rd &&
              (REQ.op == FDC_OP_READ || REQ.op == FDC_OP_WRITE)) begin
            REQ_READY <= 1'b1;
            cur <= REQ;
            state <= ST_COL;
          end else if (tmr == 16'h0) begin
            state <= ST_RAS_OFF;
          end
        end
        ST_RAS_OFF: begin
          PINS.row_strobe_n <= 2'b11;
          PINS.write_enable_n <= 1'b1;
          tmr <= 16'(PRECHARGE_CYC);
          state <= ST_IDLE;
        end
        ST_CBR_SETUP: begin
          if (tmr == 16'h0) begin
            // address not driven anew; single bank in x16 not needed
            PINS.row_strobe_n <= 2'b00;
            tmr <= 16'(COL_PULSE_CYC + PRECHARGE_CYC);
            state <= ST_CBR_ROW;
          end
        end
        ST_CBR_ROW: begin
          if (tmr == 16'h0) begin
            PINS.col_strobe_n <= '1;
            state <= ST_RAS_OFF;
          end
        end
        ST_BATT: begin
          // row pulse no longer than one microsecond
          if (tmr == 16'h0) begin
            PINS.row_strobe_n <= 2'b11;
            tmr <= 16'(PRECHARGE_CYC);
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== verification/fdc_host_sva.sv
module fdc_host_chk
  import fdc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Watched ports
  input wire logic MODE_X16,
  input wire logic RD_VALID,
  input wire logic DQ_OE,
  input wire fdc_pkg::fdc_pins_t PINS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic row_q;
  logic [7:0] gap;
  wire row_act = PINS.row_strobe_n != 2'h3;
  wire col_act = PINS.col_strobe_n != 4'hf;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Saturates so a long idle never wraps into a false short gap
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      row_q <= 1'b0;
      gap <= 8'hff;
    end else begin
      row_q <= row_act;
      gap <= (row_act && !row_q) ? 8'h1 : ((gap == 8'hff) ? gap : gap + 8'h1);
    end
  end
  property p_bank; MODE_X16 && $rose(col_act) && row_act |-> ^PINS.row_strobe_n; endproperty
  a_bank: assert property (p_bank)
    else $error("both banks strobed");
  property p_cbr_we; col_act && !row_act |-> PINS.write_enable_n; endproperty
  a_cbr_we: assert property (p_cbr_we)
    else $error("refresh with write enable low");
  property p_oe_write; DQ_OE |-> !PINS.write_enable_n; endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("data driven outside write");
  property p_oe_row; DQ_OE |-> row_act; endproperty
  a_oe_row: assert property (p_oe_row)
    else $error("data driven with row idle");
  property p_page_gap; $rose(col_act) |=> (!$rose(col_act)) [*5]; endproperty
  a_page_gap: assert property (p_page_gap)
    else $error("column cycles too close");
  property p_access; RD_VALID |-> $past(col_act, 6); endproperty
  a_access: assert property (p_access)
    else $error("read data taken too early");
  property p_ras_gap; row_act && !row_q |-> gap >= RANDOM_CYCLE_CYC; endproperty
  a_ras_gap: assert property (p_ras_gap)
    else $error("row cycles too close");
  property p_read_we; RD_VALID |-> PINS.write_enable_n && $past(PINS.write_enable_n, 4); endproperty
  a_read_we: assert property (p_read_we)
    else $error("read with write enable low");
endmodule

bind fdc_host fdc_host_chk u_chk (.CLK(CLK), .RESETN(RESETN), .MODE_X16(MODE_X16),
  .RD_VALID(RD_VALID), .DQ_OE(DQ_OE), .PINS(PINS));

// ===== verification/fdc_card_model.sv
module fdc_card_model
  import fdc_pkg::*;
(
  // Card pins
  input wire fdc_pkg::fdc_pins_t PINS,
  input wire logic [fdc_pkg::DATA_BITS-1:0] DQ_OUT,
  input wire logic DQ_OE,
  output logic [fdc_pkg::DATA_BITS-1:0] DQ_IN,
  output logic [fdc_pkg::PD_BITS-1:0] PD_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_BITS-1:0] mem [logic [WORD_ADDR_BITS-1:0]];
  logic [ROW_BITS-1:0] row = '0;
  logic [WORD_ADDR_BITS-1:0] a;
  logic [DATA_BITS-1:0] w;
  int cbr_count = 0;
  int ror_count = 0;
  logic col_seen = 1'b0;
  wire row_act = PINS.row_strobe_n != 2'h3;
  wire col_act = PINS.col_strobe_n != 4'hf;
  initial DQ_IN = 32'h0;
  assign PD_IN = 8'ha5;
  always @(posedge row_act) begin
    col_seen = col_act;
    if (col_act) cbr_count++;
    else row = PINS.addr;
  end
  // Row pulse with no column strobe is a row-only refresh
  always @(negedge row_act) begin
    if (!col_seen) ror_count++;
  end
  // released bus drifts, never holds old data
  always @(negedge col_act) DQ_IN = ~DQ_IN;
  always @(posedge col_act) begin
    if (row_act) begin
      col_seen = 1'b1;
      a = {row, PINS.addr};
      w = mem.exists(a) ? mem[a] : 32'h0;
      if (!PINS.write_enable_n) begin
        for (int i = 0; i < LANES; i++) if (!PINS.col_strobe_n[i]) w[8*i+:8] = DQ_OUT[8*i+:8];
        mem[a] = w;
      end else begin
        DQ_IN = ~DQ_IN;
        #(ADDRESS_ACCESS_TIME_NS);
        for (int i = 0; i < LANES; i++) if (!PINS.col_strobe_n[i]) DQ_IN[8*i+:8] = w[8*i+:8];
      end
    end
  end
endmodule

// ===== verification/test_fdc_host.sv
module test_fdc_host;
  timeunit 1ns;
  timeprecision 1ps;
  import fdc_pkg::*;
  logic CLK = 1'b0, RESETN = 1'b0, REQ_VALID = 1'b0, MODE_X16 = 1'b0, BATTERY_MODE = 1'b0;
  fdc_req_t REQ = '0;
  logic REQ_READY, RD_VALID, DQ_OE;
  logic [DATA_BITS-1:0] RD_DATA, DQ_OUT, DQ_IN, q;
  logic [PD_BITS-1:0] CARD_ID, PD_IN;
  fdc_pins_t PINS;
  int fail_count = 0, compares = 0, cyc = 0;
  always #4 CLK = ~CLK;
  fdc_host #(.REFRESH_CYC(200), .BATTERY_CYC(400)) u_dut (.CLK(CLK), .RESETN(RESETN),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .MODE_X16(MODE_X16), .BATTERY_MODE(BATTERY_MODE),
    .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .CARD_ID(CARD_ID),
    .PINS(PINS), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(DQ_IN), .PD_IN(PD_IN));
  fdc_card_model u_card (.PINS(PINS), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(DQ_IN),
    .PD_IN(PD_IN));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Called at a falling edge; request held until taken
  task automatic xfer(input fdc_op_t op, input logic [19:0] a, input logic [31:0] d,
                      input logic [3:0] be, input logic hold);
    int n;
    REQ_VALID = 1'b1;
    REQ = '{op, a, d, be, hold};
    for (n = 0; n < 3000 && REQ_READY !== 1'b1; n++) @(negedge CLK);
    REQ_VALID = 1'b0;
    if (op == FDC_OP_READ) for (n = 0; n < 3000 && RD_VALID !== 1'b1; n++) @(negedge CLK);
    q = RD_DATA;
    @(negedge CLK);
  endtask
  task automatic t_rw;
    xfer(FDC_OP_WRITE, 20'h12345, 32'hcafe_f00d, 4'hf, 1'b0);
    xfer(FDC_OP_WRITE, 20'h12345, 32'h0000_aa00, 4'h2, 1'b0);
    xfer(FDC_OP_READ, 20'h12345, 32'h0, 4'hf, 1'b0);
    chk(q, 32'hcafe_aa0d);
    chk(32'(CARD_ID), 32'ha5);
    $display("test rw done");
  endtask
  task automatic t_page;
    for (int i = 0; i < 3; i++) xfer(FDC_OP_WRITE, 20'h45600 + 20'(i), 32'h0101_0101 * (i + 1), 4'hf, i < 2);
    for (int i = 0; i < 3; i++) begin
      xfer(FDC_OP_READ, 20'h45600 + 20'(i), 32'h0, 4'hf, i < 2);
      chk(q, 32'h0101_0101 * (i + 1));
    end
    $display("test page done");
  endtask
  task automatic t_x16;
    MODE_X16 = 1'b1;
    xfer(FDC_OP_WRITE, 20'h80010, 32'h5a5a_0000, 4'hc, 1'b0);
    xfer(FDC_OP_WRITE, 20'h00010, 32'h0000_a5a5, 4'h3, 1'b0);
    xfer(FDC_OP_READ, 20'h80010, 32'h0, 4'hc, 1'b0);
    chk(q & 32'hffff_0000, 32'h5a5a_0000);
    xfer(FDC_OP_READ, 20'h00010, 32'h0, 4'h3, 1'b0);
    chk(q & 32'h0000_ffff, 32'h0000_a5a5);
    MODE_X16 = 1'b0;
    $display("test x16 done");
  endtask
  task automatic t_refresh;
    int pre, pre_r;
    pre = u_card.cbr_count;
    pre_r = u_card.ror_count;
    xfer(FDC_OP_REFRESH_ROW, 20'h12345, 32'h0, 4'hf, 1'b0);
    repeat (500) @(negedge CLK);
    chk(32'(u_card.cbr_count - pre > 1), 32'h1);
    chk(32'(u_card.ror_count - pre_r), 32'h1);
    xfer(FDC_OP_READ, 20'h12345, 32'h0, 4'hf, 1'b0);
    chk(q, 32'hcafe_aa0d);
    pre = u_card.cbr_count;
    xfer(FDC_OP_REFRESH_CBR, 20'h0, 32'h0, 4'h0, 1'b0);
    repeat (20) @(negedge CLK);
    chk(32'(u_card.cbr_count != pre), 32'h1);
    $display("test refresh done");
  endtask
  task automatic t_batt;
    int w = 0, peak = 0, bad = 0;
    BATTERY_MODE = 1'b1;
    repeat (1000) begin
      @(negedge CLK);
      if (PINS.row_strobe_n != 2'h3) begin
        w++;
        if (PINS.col_strobe_n == 4'hf || !PINS.write_enable_n) bad++;
      end else w = 0;
      if (w > peak) peak = w;
    end
    BATTERY_MODE = 1'b0;
    chk(32'(bad), 32'h0);
    chk(32'(peak > 0 && peak <= BATTERY_PULSE_CYC), 32'h1);
    $display("test battery done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (16) @(negedge CLK);
    RESETN = 1'b1;
    t_rw;
    t_page;
    t_x16;
    t_refresh;
    t_batt;
    wrap_up;
  end
endmodule
